/* bench/plc_memory_link_trigger_map_bench.sv */
// bench: both link ends joined, driven from the software and result ports
`timescale 1ns/10ps
module plc_memory_link_trigger_map_bench;
   import plm_pkg::*;
   localparam plm_word_t BASE = 16'h0010;
   localparam plm_word_t REC  = 16'h0040;
   logic       clock = 1'b0, rst_n = 1'b0, sw_we = 1'b0, sw_re = 1'b0, trig_go = 1'b0;
   logic       trig_val = 1'b0, trig_os = 1'b0, rel_go = 1'b0, area_en = 1'b0, os_mode = 1'b0;
   logic       fseq = 1'b0, c_we = 1'b0, r_valid = 1'b0, r_c = 1'b0, ml = 1'b0;
   logic       seq_busy, trig_done, res_ready, laser_on, os_active;
   logic [7:0] sw_addr = 8'h00, trig_time = 8'h00, c_data = 8'h00;
   logic [5:0] c_idx = 6'h00;
   logic [3:0] r_type = 4'h0;
   logic [1:0] r_label = 2'h0;
   plm_word_t  sw_wdata = 16'h0000, r_w = 16'h0001, base = BASE, sw_rdata;
   int         errors = 0, n_checks = 0, os_n = 0;
   // clock and one-shot length count
   initial forever #12.5 clock = ~clock;
   always @(posedge clock) if (os_active === 1'b1) os_n <= os_n + 1;
   plm_link_if plm_link_if_inst (.clock(clock));
   plm_reader_end #(.STEP_CYCLES(4)) plm_reader_end_inst (.clock(clock), .rst_n(rst_n),
      .link(plm_link_if_inst.reader), .head_base(base), .trig_area_en(area_en), .oneshot_mode(os_mode),
      .multi_label(ml), .type_set(4'h1), .flag_seq(fseq), .preset_steps(8'h01), .char_we(c_we),
      .char_idx(c_idx), .char_data(c_data), .res_valid(r_valid), .res_label(r_label), .res_err(1'b0),
      .res_orient(r_w), .res_dcount(r_w), .res_scount(r_w), .res_type(r_type), .res_ndig(7'h28),
      .res_start_c(r_c), .res_ready(res_ready), .laser_on(laser_on), .os_active(os_active));
   plm_ctrl_end plm_ctrl_end_inst (.clock(clock), .rst_n(rst_n), .link(plm_link_if_inst.controller),
      .trig_base(base), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re),
      .sw_rdata(sw_rdata), .trig_go(trig_go), .trig_val(trig_val), .trig_oneshot(trig_os),
      .trig_time(trig_time), .rel_go(rel_go), .rel_head(REC), .seq_busy(seq_busy), .trig_done(trig_done));
   plm_link_asserts #(.BASE(BASE), .REC(REC)) plm_link_asserts_inst (.clock(clock), .rst_n(rst_n),
      .addr(plm_link_if_inst.addr), .wdata(plm_link_if_inst.wdata), .rdata(plm_link_if_inst.rdata),
      .we(plm_link_if_inst.we), .re(plm_link_if_inst.re));
   // verdict and end of run
   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input plm_word_t exp, input plm_word_t got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   // software port write and read
   task automatic wr(input plm_word_t a, input plm_word_t d);
      @(posedge clock);
      sw_addr <= a[7:0];
      sw_wdata <= d;
      sw_we <= 1'b1;
      @(posedge clock);
      sw_we <= 1'b0;
   endtask
   task automatic rd(input plm_word_t a, input string nm, input plm_word_t exp);
      @(posedge clock);
      sw_addr <= a[7:0];
      sw_re <= 1'b1;
      @(posedge clock);
      sw_re <= 1'b0;
      #1 chk(nm, exp, sw_rdata);
   endtask
   // bounded waits on completion flags
   function automatic logic cond(input int k);
      case (k)
         0: return trig_done;
         1: return res_ready;
         2: return os_active;
         3: return !os_active;
         4: return !seq_busy;
         default: return !res_ready;
      endcase
   endfunction
   task automatic waitc(input int k);
      int i;
      i = 0;
      #1;
      while (cond(k) !== 1'b1 && i < 2000) begin
         @(posedge clock);
         #1 i++;
      end
      if (i >= 2000) begin
         errors++;
         test_done();
      end
   endtask
   task automatic trig(input logic v, input logic o, input logic [7:0] t);
      @(posedge clock);
      trig_go <= 1'b1;
      trig_val <= v;
      trig_os <= o;
      trig_time <= t;
      @(posedge clock);
      trig_go <= 1'b0;
      waitc(0);
   endtask
   task automatic rel;
      @(posedge clock);
      rel_go <= 1'b1;
      @(posedge clock);
      rel_go <= 1'b0;
      waitc(4);
   endtask
   task automatic res(input logic [3:0] ty, input logic c);
      waitc(1);
      @(posedge clock);
      r_valid <= 1'b1;
      r_type <= ty;
      r_c <= c;
      @(posedge clock);
      r_valid <= 1'b0;
      waitc(5);
      waitc(1);
   endtask
   task automatic rec(input plm_word_t fl, input plm_word_t o, input plm_word_t ty, input plm_word_t n,
                      input plm_word_t last);
      rd(REC, "flag", fl);
      rd(REC + 16'h0001, "orient", o);
      rd(REC + 16'h0003, "scan count", o);
      rd(REC + 16'h0004, "type", ty);
      rd(REC + 16'h0005, "digits", n);
      rd(REC + 16'h0005 + n, "last char", last);
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      wr(BASE, REC);
      wr(BASE + 16'h0004, 16'h0001); // request left standing while the trigger area is off
      for (int i = 5; i < 7; i++) wr(BASE + 16'(i), 16'h0000);
      for (int i = 0; i < 40; i++) begin
         @(posedge clock);
         c_we <= 1'b1;
         c_idx <= 6'(i);
         c_data <= 8'h41 + 8'(i);
      end
      @(posedge clock);
      c_we <= 1'b0;
      rd(BASE + 16'h0004, "idle trigger", 16'h0001);
      rd(BASE + 16'h0005, "idle ack", 16'h0000);
      wr(BASE + 16'h0004, 16'h0000);
      area_en <= 1'b1; // trigger words used only once the area is on
      trig(1'b1, 1'b0, 8'h00);
      chk("laser on", 16'h0001, 16'(laser_on));
      rd(BASE + 16'h0005, "ack", 16'h0000);
      res(4'h0, 1'b0);
      rec(16'h0000, 16'h0001, 16'h0000, 16'h0020, 16'h0060);
      @(posedge clock);
      fseq <= 1'b1;
      rel();
      res(4'h5, 1'b1);
      rec(16'h0003, 16'h0001, 16'h0005, 16'h0028, 16'h0068);
      trig(1'b0, 1'b0, 8'h00);
      chk("laser off", 16'h0000, 16'(laser_on));
      rel();
      @(posedge clock);
      ml <= 1'b1;
      r_label <= 2'h1;
      res(4'h0, 1'b0);
      rd(REC, "dropped flag", 16'h0002);
      @(posedge clock);
      ml <= 1'b0;
      os_mode <= 1'b1;
      trig(1'b1, 1'b1, 8'h02);
      waitc(2);
      waitc(3);
      chk("scan time", 16'h0008, 16'(os_n));
      repeat (300) @(posedge clock);
      rd(BASE + 16'h0004, "trigger", 16'h0000);
      rd(BASE + 16'h0006, "time", 16'h0002);
      rec(16'h0003, 16'h0000, 16'h0007, 16'h0005, 16'h0052);
      test_done();
   end
endmodule

/* bench/plm_link_asserts.sv */
// checker of the reader to controller memory link traffic
`timescale 1ns/10ps
module plm_link_asserts #(
   parameter logic [15:0] BASE = 16'h0010,  // trigger words head
   parameter logic [15:0] REC  = 16'h0040   // record head a
) (
   input wire logic               clock,  // clock
   input wire logic               rst_n,  // reset, active low
   input wire plm_pkg::plm_word_t addr,   // word address
   input wire plm_pkg::plm_word_t wdata,  // write data
   input wire plm_pkg::plm_word_t rdata,  // read data
   input wire logic               we,     // write strobe
   input wire logic               re      // read strobe
);
   import plm_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // decoded writes of the three trigger words and reads of words 4 and 6
   wire w4 = we && addr == BASE + 16'h0004;
   wire w5 = we && addr == BASE + 16'h0005;
   wire w6 = we && addr == BASE + 16'h0006;
   wire r4 = re && addr == BASE + 16'h0004;
   wire r6 = re && addr == BASE + 16'h0006;
   // steps of a record write
   sequence rec_open; we && addr == REC && wdata == 16'h0001; endsequence
   sequence rec_body; ##[1:3] (we && addr == REC + 16'h0001); endsequence
   strobe_excl_a: assert property (!(we && re)) else $error("both strobes high");
   reset_quiet_a: assert property ($rose(rst_n) |-> !we && !re && addr == 16'h0000) else $error("link busy at reset");
   ack_one_a: assert property (w5 |-> wdata == 16'h0001) else $error("ack not one");
   ack_poll_a: assert property (w5 |-> $past(r4, 2)) else $error("ack without poll");
   os_clear_a: assert property (w4 |-> wdata == 16'h0000) else $error("trigger not cleared");
   os_time_a: assert property (w4 |=> r6) else $error("time word not read");
   time_ro_a: assert property (!w6) else $error("time word written");
   rec_order_a: assert property (rec_open |-> rec_body) else $error("record order");
   ndig_max_a: assert property (we && addr == REC + 16'h0005 |-> wdata <= 16'h0040) else $error("too many digits");
   char_end_a: assert property (!(we && addr == REC + 16'h0046)) else $error("write past record");
endmodule

/* logic/plm_ctrl_end.sv */
// controller end: word memory, software port and trigger handshake sequencer
`timescale 1ns/10ps
`include "plm_defs.svh"
module plm_ctrl_end (
   input  wire logic              clock,         // 40 MHz clock
   input  wire logic              rst_n,         // synchronous reset, active low
   plm_link_if.controller         link,          // memory link
   input  wire plm_pkg::plm_word_t trig_base,    // head address of trigger words
   input  wire logic [7:0]        sw_addr,       // software word address
   input  wire plm_pkg::plm_word_t sw_wdata,     // software write data
   input  wire logic              sw_we,         // software write strobe
   input  wire logic              sw_re,         // software read strobe
   output plm_pkg::plm_word_t     sw_rdata,      // software read data
   input  wire logic              trig_go,       // start trigger change
   input  wire logic              trig_val,      // new trigger level
   input  wire logic              trig_oneshot,  // one-shot request
   input  wire logic [7:0]        trig_time,     // one-shot scan steps
   input  wire logic              rel_go,        // release sequential record
   input  wire plm_pkg::plm_word_t rel_head,     // record head to release
   output logic                   seq_busy,      // sequencer working
   output logic                   trig_done      // trigger change complete
);
   import plm_pkg::*;

   plm_word_t      mem [0:`PLM_MEM_DEPTH-1];
   plm_ctl_state_t cstate;
   logic           val_r;
   logic           os_r;
   logic [7:0]     time_r;
   plm_word_t      rel_r;
   logic           seq_want;
   plm_word_t      seq_addr;
   plm_word_t      seq_data;

   // sequencer write request by state
   always_comb begin
      seq_want = 1'b1;
      seq_addr = trig_base + `PLM_OFS_ACK;
      seq_data = `PLM_ZERO;
      case (cstate)
         PLM_C_TIME: begin
            seq_addr = trig_base + `PLM_OFS_TIME;
            seq_data = {8'h00, time_r};
         end
         PLM_C_SET4: begin
            seq_addr = trig_base + `PLM_OFS_TRIG;
            seq_data = {15'h0000, val_r};
         end
         PLM_C_REL: begin
            seq_addr = rel_r;
            seq_data = `PLM_FLAG_FREE;
         end
         PLM_C_CLR5, PLM_C_CLR5B: begin
            seq_want = 1'b1;
         end
         default: begin
            seq_want = 1'b0;
         end
      endcase
   end

   // link writes win, then software, then sequencer
   wire       grant   = seq_want && !link.we && !sw_we;
   wire [7:0] ack_idx = 8'(trig_base + `PLM_OFS_ACK);
   wire       ack_one = mem[ack_idx] == `PLM_ONE;

   // word memory with two read ports
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         link.rdata <= 16'h0000;
         sw_rdata   <= 16'h0000;
      end else begin
         if (link.we) begin
            mem[link.addr[7:0]] <= link.wdata;
         end else if (grant) begin
            mem[seq_addr[7:0]] <= seq_data;
         end else if (sw_we) begin
            mem[sw_addr] <= sw_wdata;
         end
         if (link.re) begin
            link.rdata <= mem[link.addr[7:0]];
         end
         if (sw_re) begin
            sw_rdata <= mem[sw_addr];
         end
      end
   end

   // trigger handshake and record release sequencer
   always_ff @(posedge clock) begin
      trig_done <= 1'b0;
      if (!rst_n) begin
         cstate   <= PLM_C_IDLE;
         seq_busy <= 1'b0;
         val_r    <= 1'b0;
         os_r     <= 1'b0;
         time_r   <= 8'h00;
         rel_r    <= 16'h0000;
      end else begin
         case (cstate)
            PLM_C_IDLE: begin
               if (trig_go) begin
                  val_r    <= trig_val || trig_oneshot;
                  os_r     <= trig_oneshot;
                  time_r   <= trig_time;
                  seq_busy <= 1'b1;
                  cstate   <= trig_oneshot ? PLM_C_TIME : PLM_C_CLR5;
               end else if (rel_go) begin
                  rel_r    <= rel_head;
                  seq_busy <= 1'b1;
                  cstate   <= PLM_C_REL;
               end
            end
            PLM_C_TIME: begin
               if (grant) begin
                  cstate <= PLM_C_SET4;
               end
            end
            PLM_C_CLR5: begin
               if (grant) begin
                  cstate <= PLM_C_SET4;
               end
            end
            PLM_C_SET4: begin
               if (grant) begin
                  cstate <= os_r ? PLM_C_IDLE : PLM_C_WAIT;
                  seq_busy  <= !os_r;
                  trig_done <= os_r;
               end
            end
            PLM_C_WAIT: begin
               if (ack_one) begin
                  cstate <= PLM_C_CLR5B;
               end
            end
            PLM_C_CLR5B: begin
               if (grant) begin
                  cstate    <= PLM_C_IDLE;
                  seq_busy  <= 1'b0;
                  trig_done <= 1'b1;
               end
            end
            PLM_C_REL: begin
               if (grant) begin
                  cstate   <= PLM_C_IDLE;
                  seq_busy <= 1'b0;
               end
            end
            default: begin
               cstate <= PLM_C_IDLE;
            end
         endcase
      end
   end
endmodule

/* logic/plm_defs.svh */
// constants of the controller memory link: offsets, record layout, codes and timing
`ifndef PLM_DEFS_SVH
`define PLM_DEFS_SVH
// trigger words, relative to the configured head address
`define PLM_OFS_TRIG   16'h0004
`define PLM_OFS_ACK    16'h0005
`define PLM_OFS_TIME   16'h0006
// data record words, relative to record head a
`define PLM_REC_FLAG   7'h00
`define PLM_REC_ORIENT 7'h01
`define PLM_REC_DCNT   7'h02
`define PLM_REC_SCNT   7'h03
`define PLM_REC_TYPE   7'h04
`define PLM_REC_NDIG   7'h05
`define PLM_REC_CHAR0  7'h06
// character field limits
`define PLM_MAX_CHARS  7'h40
`define PLM_STD_CHARS  7'h20
// flag word values
`define PLM_FLAG_BUSY  16'h0001
`define PLM_FLAG_DONE  16'h0000
`define PLM_FLAG_FREE  16'h0002
`define PLM_FLAG_FULL  16'h0003
// handshake word values
`define PLM_ONE        16'h0001
`define PLM_ZERO       16'h0000
// bar code types
`define PLM_TYPE_ERR   16'h0007
`define PLM_TYPE_C128  4'h5
// read error code text
`define PLM_ERR_LEN    7'h05
`define PLM_ERR_C0     8'h45
`define PLM_ERR_C1     8'h52
`define PLM_ERR_C2     8'h4f
// timing and memory depth
`define PLM_STEP_MS    100
`define PLM_CLK_KHZ    40000
`define PLM_MEM_DEPTH  256
`endif

/* logic/plm_link_if.sv */
// word access link from the reader into the controller memory
`timescale 1ns/10ps
interface plm_link_if (
   input wire logic clock     // common clock
);
   plm_pkg::plm_word_t addr;    // word address
   plm_pkg::plm_word_t wdata;   // write data
   plm_pkg::plm_word_t rdata;   // read data, cycle after re
   logic               we;      // write strobe
   logic               re;      // read strobe
   modport reader (input clock, output addr, output wdata, output we, output re, input rdata);
   modport controller (input clock, input addr, input wdata, input we, input re, output rdata);
endinterface

/* logic/plm_pkg.sv */
// types shared by both ends of the controller memory link
package plm_pkg;
   typedef logic [15:0] plm_word_t;
   typedef enum {
      PLM_IDLE, PLM_RW, PLM_TRIG, PLM_OSRD, PLM_OSTIME, PLM_HEAD, PLM_FLAG, PLM_WR, PLM_FIN
   } plm_dev_state_t;
   typedef enum {
      PLM_C_IDLE, PLM_C_TIME, PLM_C_CLR5, PLM_C_SET4, PLM_C_WAIT, PLM_C_CLR5B, PLM_C_REL
   } plm_ctl_state_t;
endpackage

/* logic/plm_reader_end.sv */
// reader end: polls trigger words and writes data records into controller memory
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "plm_defs.svh"
module plm_reader_end #(
   parameter int unsigned STEP_CYCLES = `PLM_STEP_MS * `PLM_CLK_KHZ  // cycles per 100 ms step
) (
   input  wire logic              clock,         // 40 MHz clock
   input  wire logic              rst_n,         // synchronous reset, active low
   plm_link_if.reader             link,          // memory link
   input  wire plm_pkg::plm_word_t head_base,    // configured head address
   input  wire logic              trig_area_en,  // trigger words in use
   input  wire logic              oneshot_mode,  // one-shot trigger, else level
   input  wire logic              multi_label,   // multi-label read mode 3
   input  wire logic [3:0]        type_set,      // label types configured
   input  wire logic              flag_seq,      // sequential flag mode
   input  wire logic [7:0]        preset_steps,  // preset scan time in steps
   input  wire logic              char_we,       // character store strobe
   input  wire logic [5:0]        char_idx,      // character position
   input  wire logic [7:0]        char_data,     // character code
   input  wire logic              res_valid,     // result offered
   input  wire logic [1:0]        res_label,     // label number
   input  wire logic              res_err,       // read failure
   input  wire plm_pkg::plm_word_t res_orient,   // label orientation
   input  wire plm_pkg::plm_word_t res_dcount,   // decode count
   input  wire plm_pkg::plm_word_t res_scount,   // scan count
   input  wire logic [3:0]        res_type,      // bar code type
   input  wire logic [6:0]        res_ndig,      // digit count
   input  wire logic              res_start_c,   // code 128 starts in subset c
   output logic                   res_ready,     // result can be taken
   output logic                   laser_on,      // scanning with laser on
   output logic                   os_active      // one-shot scan time running
);
   import plm_pkg::*;

   localparam logic [21:0] STEP_LAST = 22'(STEP_CYCLES - 1);

   plm_dev_state_t state;
   plm_dev_state_t rd_ret;
   logic [7:0]     chars [0:63];
   logic           pend;
   logic           err_r;
   logic           use_err;
   plm_word_t      orient_r;
   plm_word_t      dcnt_r;
   plm_word_t      scnt_r;
   logic [3:0]     type_r;
   logic [6:0]     ndig_r;
   logic [1:0]     lab_r;
   logic           last_trig;
   logic           lvl_on;
   logic           os_due;
   logic           os_load;
   logic [7:0]     os_steps;
   logic [7:0]     steps;
   logic [21:0]    sub;
   logic           os_fire;
   plm_word_t      head;
   logic [6:0]     wi;
   plm_word_t      next_word;

   // error text character by position
   function automatic logic [7:0] err_char(input logic [5:0] i);
      case (i)
         6'h00:   err_char = `PLM_ERR_C0;
         6'h03:   err_char = `PLM_ERR_C2;
         default: err_char = `PLM_ERR_C1;
      endcase
   endfunction

   // record length, last word index, digit limit and skip decision
   wire            take     = res_valid && res_ready;
   wire [6:0]      lim      = (res_type == `PLM_TYPE_C128 && res_start_c) ? `PLM_MAX_CHARS : `PLM_STD_CHARS;
   wire [6:0]      cap_ndig = (res_ndig > lim) ? lim : res_ndig;
   wire [6:0]      rec_len  = use_err ? `PLM_ERR_LEN : ndig_r;
   wire [6:0]      last_wi  = 7'(`PLM_REC_NDIG + rec_len);
   wire [5:0]      ci       = 6'(wi - `PLM_REC_CHAR0);
   wire [1:0]      lab_use  = multi_label ? lab_r : 2'h0;
   wire            drop     = pend && multi_label && !type_set[lab_r];
   wire            rec_due  = os_due || (pend && !oneshot_mode);
   wire [7:0]      os_pick  = (link.rdata[7:0] == 8'h00) ? preset_steps : link.rdata[7:0];

   // word written at each record position
   always_comb begin
      case (wi)
         `PLM_REC_FLAG:   next_word = `PLM_FLAG_BUSY;
         `PLM_REC_ORIENT: next_word = use_err ? `PLM_ZERO : orient_r;
         `PLM_REC_DCNT:   next_word = use_err ? `PLM_ZERO : dcnt_r;
         `PLM_REC_SCNT:   next_word = use_err ? `PLM_ZERO : scnt_r;
         `PLM_REC_TYPE:   next_word = use_err ? `PLM_TYPE_ERR : {12'h000, type_r};
         `PLM_REC_NDIG:   next_word = {9'h000, rec_len};
         default:         next_word = {8'h00, use_err ? err_char(ci) : chars[ci]};
      endcase
   end

   // character store, locked while a result is held or written
   genvar g;
   generate
      for (g = 0; g < 64; g = g + 1) begin : g_char
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               chars[g] <= 8'h00;
            end else if (char_we && res_ready && char_idx == 6'(g)) begin
               chars[g] <= char_data;
            end
         end
      end
   endgenerate

   // one-shot scan timer in 100 ms steps
   always_ff @(posedge clock) begin
      os_fire <= 1'b0;
      if (!rst_n) begin
         os_active <= 1'b0;
         steps     <= 8'h00;
         sub       <= 22'h000000;
      end else if (os_load) begin
         os_active <= 1'b1;
         steps     <= os_steps;
         sub       <= STEP_LAST;
      end else if (os_active) begin
         if (sub != 22'h000000) begin
            sub <= sub - 22'h000001;
         end else if (steps <= 8'h01) begin
            os_active <= 1'b0;
            os_fire   <= 1'b1;
         end else begin
            steps <= steps - 8'h01;
            sub   <= STEP_LAST;
         end
      end
   end

   // laser follows the level trigger or the one-shot timer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         laser_on <= 1'b0;
      end else begin
         laser_on <= oneshot_mode ? os_active : lvl_on;
      end
   end

   // link master: trigger polling and record writing
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state      <= PLM_IDLE;
         rd_ret     <= PLM_IDLE;
         link.addr  <= 16'h0000;
         link.wdata <= 16'h0000;
         link.we    <= 1'b0;
         link.re    <= 1'b0;
         pend       <= 1'b0;
         res_ready  <= 1'b1;
         err_r      <= 1'b0;
         use_err    <= 1'b0;
         orient_r   <= 16'h0000;
         dcnt_r     <= 16'h0000;
         scnt_r     <= 16'h0000;
         type_r     <= 4'h0;
         ndig_r     <= 7'h00;
         lab_r      <= 2'h0;
         last_trig  <= 1'b0;
         lvl_on     <= 1'b0;
         os_due     <= 1'b0;
         os_load    <= 1'b0;
         os_steps   <= 8'h00;
         head       <= 16'h0000;
         wi         <= 7'h00;
      end else begin
         link.we <= 1'b0;
         link.re <= 1'b0;
         os_load <= 1'b0;
         if (take) begin
            pend      <= 1'b1;
            res_ready <= 1'b0;
            err_r     <= res_err;
            orient_r  <= res_orient;
            dcnt_r    <= res_dcount;
            scnt_r    <= res_scount;
            type_r    <= res_type;
            ndig_r    <= cap_ndig;
            lab_r     <= res_label;
         end
         case (state)
            PLM_IDLE: begin
               if (drop && !take) begin
                  pend      <= 1'b0;
                  res_ready <= 1'b1;
                  os_due    <= 1'b0;
               end else if (rec_due && !take) begin
                  res_ready <= 1'b0;
                  use_err   <= !pend || err_r;
                  link.addr <= head_base + 16'(lab_use);
                  link.re   <= 1'b1;
                  rd_ret    <= PLM_HEAD;
                  state     <= PLM_RW;
               end else if (trig_area_en) begin
                  link.addr <= head_base + `PLM_OFS_TRIG;
                  link.re   <= 1'b1;
                  rd_ret    <= PLM_TRIG;
                  state     <= PLM_RW;
               end
            end
            PLM_RW: begin
               state <= rd_ret;
            end
            PLM_TRIG: begin
               state <= PLM_IDLE;
               if (!oneshot_mode && link.rdata[0] != last_trig) begin
                  last_trig  <= link.rdata[0];
                  lvl_on     <= link.rdata[0];
                  link.addr  <= head_base + `PLM_OFS_ACK;
                  link.wdata <= `PLM_ONE;
                  link.we    <= 1'b1;
               end else if (oneshot_mode && link.rdata == `PLM_ONE) begin
                  link.addr  <= head_base + `PLM_OFS_TRIG;
                  link.wdata <= `PLM_ZERO;
                  link.we    <= 1'b1;
                  state      <= PLM_OSRD;
               end
            end
            PLM_OSRD: begin
               link.addr <= head_base + `PLM_OFS_TIME;
               link.re   <= 1'b1;
               rd_ret    <= PLM_OSTIME;
               state     <= PLM_RW;
            end
            PLM_OSTIME: begin
               os_steps <= (os_pick == 8'h00) ? 8'h01 : os_pick;
               os_load  <= 1'b1;
               state    <= PLM_IDLE;
            end
            PLM_HEAD: begin
               head <= link.rdata;
               if (flag_seq) begin
                  link.addr <= link.rdata;
                  link.re   <= 1'b1;
                  rd_ret    <= PLM_FLAG;
                  state     <= PLM_RW;
               end else begin
                  wi    <= `PLM_REC_FLAG;
                  state <= PLM_WR;
               end
            end
            PLM_FLAG: begin
               if (link.rdata == `PLM_FLAG_FREE) begin
                  wi    <= `PLM_REC_ORIENT;
                  state <= PLM_WR;
               end else begin
                  res_ready <= !pend;
                  state     <= PLM_IDLE;
               end
            end
            PLM_WR: begin
               link.addr  <= head + 16'(wi);
               link.wdata <= next_word;
               link.we    <= 1'b1;
               if (wi == last_wi) begin
                  state <= PLM_FIN;
               end else begin
                  wi <= wi + 7'h01;
               end
            end
            PLM_FIN: begin
               link.addr  <= head;
               link.wdata <= flag_seq ? `PLM_FLAG_FULL : `PLM_FLAG_DONE;
               link.we    <= 1'b1;
               pend       <= 1'b0;
               res_ready  <= 1'b1;
               os_due     <= 1'b0;
               state      <= PLM_IDLE;
            end
            default: begin
               state <= PLM_IDLE;
            end
         endcase
         if (os_fire) begin
            os_due <= 1'b1;
         end
      end
   end
endmodule
